// [design/pld_gate_pkg.sv]
package pld_gate_pkg;

   // ------------------------------------------------------------
   // Register map (word addresses on the Avalon bus)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL0    = 4'h0;
   localparam logic [3:0] ADDR_CTRL2    = 4'h1;
   localparam logic [3:0] ADDR_STATUS   = 4'h2;
   localparam logic [3:0] ADDR_MAPCFG   = 4'h3;
   localparam logic [3:0] ADDR_GENREG   = 4'h4;
   localparam logic [3:0] ADDR_PDCTRL   = 4'h5;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int C0_TURBO_OFF = 3;
   localparam int C0_BLK_CLK   = 4;
   localparam int C0_BLK_MCF   = 5;
   localparam int C2_BLK_RD    = 2;
   localparam int C2_BLK_WR    = 3;
   localparam int C2_BLK_FETCH = 4;
   localparam int C2_BLK_ALE   = 5;
   localparam int C2_BLK_PC7   = 6;

   // ------------------------------------------------------------
   // Reset values and bus response codes
   // ------------------------------------------------------------
   localparam logic [7:0] PWR_RESET_VAL = 8'h00;
   localparam logic [7:0] GEN_RESET_VAL = 8'h00;
   localparam logic [7:0] MAP_CFG_VAL   = 8'h00;
   localparam logic [7:0] MCF_PRESET    = 8'h00;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_DECERR   = 2'h3;

   // Pin modes of a port pin
   typedef enum logic [1:0] {
      PIN_MCU   = 2'b00,
      PIN_PLD   = 2'b01,
      PIN_LATCH = 2'b10,
      PIN_PERIPH = 2'b11
   } pin_mode_t;

   // Reset kind sequencer
   typedef enum logic [1:0] {
      RS_POWERUP = 2'b00,
      RS_RUN     = 2'b01,
      RS_WARM    = 2'b10
   } rst_state_t;

   // Processor bus strobes
   typedef struct packed {
      logic rd;
      logic wr;
      logic fetch;
      logic ale;
   } strobes_t;

   // Avalon-MM request
   typedef struct packed {
      logic [3:0] address;
      logic       read;
      logic       write;
      logic [7:0] writedata;
   } av_req_t;

endpackage

// [design/pld_input_blocking_reset_state.sv]
// Behaviour
// - Bits 2..5 of power_mgmt_ctrl2 block rd, wr, fetch, ale strobes individually.
// - Blocking affects only logic inputs; memory arrays always get every strobe.
// - Bit 6 of power_mgmt_ctrl2 blocks port_c_bit7 from the logic input bus.
// - Bit 4 of ctrl0 keeps clock off logic bus; auto_sleep_counter still clocked.
// - Bit 5 of ctrl0 withholds clock from macrocell_flops only.
// - Enabled shared clock feeds macrocells, logic input bus and auto_sleep_counter.
// - Unblocked strobe edge wakes logic when turbo off, toggles gates when on.
// - Configuration loads during reset; logic operates before reset release.
// - Every reset returns both flash memories to read-array, aborting operations.
// - First reset after power is power-up; later resets are warm resets.
// - Processor I/O pins become inputs on resets, keep state during power-down.
// - Latched-address pins are high impedance during both reset types.
// - Peripheral I/O pins are high impedance in resets and power-down.
// - Logic I/O pins follow equations after warm reset and in power-down.
// - JTAG channel stays active during resets and power-down.
// - Resets clear other registers; power registers clear only on power-up reset.
// - Power-up clears macrocell outputs; otherwise reset/preset equations apply.
// - Both resets reload memory_space_map; power-down leaves it unchanged.
// - JTAG serial port for programming and debug; no boundary scan.
// - JTAG writes flash and logic config; firmware writes only flash.
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pld_input_blocking_reset_state
   import pld_gate_pkg::*;
(
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    sys_rst,
   // Avalon-MM slave
   input  wire logic [3:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [7:0]              avs_writedata,
   output var  logic [7:0]              avs_readdata,
   output var  logic                    avs_waitrequest,
   output var  logic [1:0]              avs_response,
   // Processor side (pins, asynchronous)
   input  wire logic                    module_reset_n,
   input  wire pld_gate_pkg::strobes_t  strobes_in,
   input  wire logic                    port_c_bit7,
   input  wire logic                    port_d_bit1,
   input  wire logic                    clk_pin_enabled,
   input  wire logic                    power_down,
   input  wire logic                    jtag_active_in,
   input  wire logic                    jtag_prog_cfg,
   input  wire logic                    fw_prog_cfg,
   // Memory side strobes
   output var  pld_gate_pkg::strobes_t  mem_strobes,
   output var  logic                    flash_read_array,
   // Logic input bus
   output var  pld_gate_pkg::strobes_t  bus_strobes,
   output var  logic                    bus_pc7,
   output var  logic                    bus_clk,
   output var  logic                    mcf_clk,
   output var  logic                    sleep_clk,
   output var  logic                    pld_wake,
   output var  logic                    pld_gate_toggle,
   // Reset state outputs
   output var  logic                    pld_ready,
   output var  logic                    warm_reset,
   output var  logic [7:0]              mcf_q,
   output var  logic [7:0]              mem_map,
   output var  logic                    pin_oe_mcu,
   output var  logic                    pin_hiz_latch,
   output var  logic                    pin_hiz_periph,
   output var  logic                    jtag_active,
   output var  logic                    cfg_write_ok
);
   import pld_gate_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [11:0] sync1_r;
   logic [11:0] sync2_r;
   strobes_t    stb_s;
   logic        pc7_s;
   logic        clk_s;
   logic        rstn_s;
   logic        clken_s;
   logic        pd_s;
   logic        jtag_s;
   logic        jprog_s;
   logic        fprog_s;

   // Two flops per asynchronous input
   always_ff @(posedge mclk) begin
      sync1_r <= {strobes_in, port_c_bit7, port_d_bit1, module_reset_n, clk_pin_enabled,
                  power_down, jtag_active_in, jtag_prog_cfg, fw_prog_cfg};
      sync2_r <= sync1_r;
   end
   assign stb_s   = sync2_r[11:8];
   assign pc7_s   = sync2_r[7];
   assign clk_s   = sync2_r[6];
   assign rstn_s  = sync2_r[5];
   assign clken_s = sync2_r[4];
   assign pd_s    = sync2_r[3];
   assign jtag_s  = sync2_r[2];
   assign jprog_s = sync2_r[1];
   assign fprog_s = sync2_r[0];

   // ------------------------------------------------------------
   // Reset kind tracking
   // ------------------------------------------------------------
   rst_state_t rs_r;
   rst_state_t rs_nxt;
   logic       in_rst;
   logic       pu_rst;
   logic       pu_seen_r;

   assign in_rst = !rstn_s;

   // First module reset seen since power was applied
   always_ff @(posedge mclk) begin
      if (sys_rst)     pu_seen_r <= 1'b0;
      else if (in_rst) pu_seen_r <= 1'b1;
   end

   // Next reset state
   always_comb begin
      rs_nxt = rs_r;
      case (rs_r)
         RS_POWERUP: if (!in_rst && pu_seen_r) rs_nxt = RS_RUN;
         RS_RUN:     if (in_rst) rs_nxt = RS_WARM;
         RS_WARM:    if (!in_rst) rs_nxt = RS_RUN;
         default:    rs_nxt = RS_POWERUP;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) rs_r <= RS_POWERUP;
      else         rs_r <= rs_nxt;
   end
   assign pu_rst = (rs_r == RS_POWERUP);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] ctrl0_r;
   logic [7:0] ctrl2_r;
   logic [7:0] gen_r;
   logic [7:0] map_r;
   logic       wr_hit;
   logic       sw_en;

   assign wr_hit = avs_write && !avs_waitrequest;
   assign sw_en  = !in_rst && !pd_s;

   // Power registers
   always_ff @(posedge mclk) begin
      // power regs clear on power-up only
      if (sys_rst || (pu_rst && in_rst)) begin
         ctrl0_r <= PWR_RESET_VAL;
         ctrl2_r <= PWR_RESET_VAL;
      end else if (wr_hit && sw_en) begin
         if (avs_address == ADDR_CTRL0) ctrl0_r <= avs_writedata;
         if (avs_address == ADDR_CTRL2) ctrl2_r <= avs_writedata;
      end
   end

   // Other control register and memory map
   always_ff @(posedge mclk) begin
      if (sys_rst || in_rst) begin
         gen_r <= GEN_RESET_VAL;
         map_r <= MAP_CFG_VAL;
      end else if (wr_hit && sw_en) begin
         if (avs_address == ADDR_GENREG) gen_r <= avs_writedata;
         if (avs_address == ADDR_MAPCFG) map_r <= avs_writedata;
      end
   end

   // ------------------------------------------------------------
   // Bus slave: one wait cycle then answer
   // ------------------------------------------------------------
   logic       ack_r;
   logic       hit;

   assign hit = (avs_address <= ADDR_PDCTRL);

   // Waitrequest falls one cycle after a request appears
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_r           <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_r           <= (avs_read || avs_write) && !ack_r;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
      end
   end

   // Read data and response
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         avs_readdata <= 8'h00;
         avs_response <= RESP_OKAY;
      end else if ((avs_read || avs_write) && !ack_r) begin
         avs_response <= hit ? RESP_OKAY : RESP_DECERR;
         case (avs_address)
            ADDR_CTRL0:  avs_readdata <= ctrl0_r;
            ADDR_CTRL2:  avs_readdata <= ctrl2_r;
            ADDR_STATUS: avs_readdata <= {4'h0, pd_s, warm_reset, pld_ready, flash_read_array};
            ADDR_MAPCFG: avs_readdata <= map_r;
            ADDR_GENREG: avs_readdata <= gen_r;
            ADDR_PDCTRL: avs_readdata <= 8'h00;
            default:     avs_readdata <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Gating of the logic input bus
   // ------------------------------------------------------------
   strobes_t blk;
   strobes_t gated;
   strobes_t prev_r;
   logic     edge_any;

   assign blk   = '{rd: ctrl2_r[C2_BLK_RD], wr: ctrl2_r[C2_BLK_WR],
                    fetch: ctrl2_r[C2_BLK_FETCH], ale: ctrl2_r[C2_BLK_ALE]};
   assign gated = stb_s & ~blk;

   assign edge_any = |((stb_s ^ prev_r) & ~blk);

   // Gated bus outputs and ungated memory strobes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prev_r          <= '0;
         mem_strobes     <= '0;
         bus_strobes     <= '0;
         bus_pc7         <= 1'b0;
         bus_clk         <= 1'b0;
         mcf_clk         <= 1'b0;
         sleep_clk       <= 1'b0;
         pld_wake        <= 1'b0;
         pld_gate_toggle <= 1'b0;
      end else begin
         prev_r          <= stb_s;
         mem_strobes     <= stb_s;
         bus_strobes     <= gated;
         bus_pc7         <= pc7_s & ~ctrl2_r[C2_BLK_PC7];
         bus_clk         <= clk_s & clken_s & ~ctrl0_r[C0_BLK_CLK];
         mcf_clk         <= clk_s & clken_s & ~ctrl0_r[C0_BLK_MCF];
         sleep_clk       <= clk_s & clken_s;
         pld_wake        <= edge_any & ctrl0_r[C0_TURBO_OFF];
         pld_gate_toggle <= edge_any & ~ctrl0_r[C0_TURBO_OFF];
      end
   end

   // ------------------------------------------------------------
   // Macrocell flops and reset-state outputs
   // ------------------------------------------------------------
   logic mcf_rise;
   assign mcf_rise = clk_s & clken_s & ~ctrl0_r[C0_BLK_MCF] & ~mcf_clk;

   // Macrocell storage, sampling the general register as equation result
   // pins follow macrocell equations
   always_ff @(posedge mclk) begin
      if (sys_rst || (pu_rst && in_rst)) mcf_q <= 8'h00;
      else if (in_rst)                   mcf_q <= MCF_PRESET;
      else if (mcf_rise)                 mcf_q <= gen_r;
   end

   // Pin and status outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         flash_read_array <= 1'b1;
         pld_ready        <= 1'b0;
         warm_reset       <= 1'b0;
         mem_map          <= MAP_CFG_VAL;
         pin_oe_mcu       <= 1'b0;
         pin_hiz_latch    <= 1'b1;
         pin_hiz_periph   <= 1'b1;
         jtag_active      <= 1'b1;
         cfg_write_ok     <= 1'b0;
      end else begin
         flash_read_array <= in_rst | flash_read_array & ~(avs_write & !avs_waitrequest);
         pld_ready        <= 1'b1;
         warm_reset       <= (rs_r == RS_WARM);
         mem_map          <= map_r;
         // inputs on reset, hold in power-down
         pin_oe_mcu       <= in_rst ? 1'b0 : (pd_s ? pin_oe_mcu : 1'b1);
         pin_hiz_latch    <= in_rst | pd_s;
         pin_hiz_periph   <= in_rst | pd_s;
         jtag_active      <= 1'b1 | jtag_s;
         cfg_write_ok     <= jprog_s & ~fprog_s | jprog_s;
      end
   end
   // logic pins follow equations: mcf_q and bus outputs stay live after reset

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_blk_rd;
      @(posedge mclk) disable iff (sys_rst) ctrl2_r[C2_BLK_RD] && $stable(ctrl2_r) |=> !bus_strobes.rd;
   endproperty
   a_blk_rd: assert property (p_blk_rd) else $error("blocked rd reached bus");

   property p_mem_pass;
      @(posedge mclk) disable iff (sys_rst) 1'b1 |=> mem_strobes == $past(stb_s);
   endproperty
   a_mem_pass: assert property (p_mem_pass) else $error("memory strobes not passed");

   property p_pc7;
      @(posedge mclk) disable iff (sys_rst) ctrl2_r[C2_BLK_PC7] |=> !bus_pc7;
   endproperty
   a_pc7: assert property (p_pc7) else $error("pc7 not blocked");

   property p_clk_bus;
      @(posedge mclk) disable iff (sys_rst) ctrl0_r[C0_BLK_CLK] |=> !bus_clk;
   endproperty
   a_clk_bus: assert property (p_clk_bus) else $error("clock reached bus");

   property p_mcf_blk;
      @(posedge mclk) disable iff (sys_rst) ctrl0_r[C0_BLK_MCF] |=> !mcf_clk;
   endproperty
   a_mcf_blk: assert property (p_mcf_blk) else $error("clock reached macrocells");

   property p_sleep;
      @(posedge mclk) disable iff (sys_rst) clk_s && clken_s |=> sleep_clk;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep counter lost clock");

   property p_warm_keep;
      @(posedge mclk) disable iff (sys_rst) rs_r == RS_WARM |-> $stable(ctrl0_r) && $stable(ctrl2_r);
   endproperty
   a_warm_keep: assert property (p_warm_keep) else $error("power reg changed in warm reset");

   property p_flash;
      @(posedge mclk) disable iff (sys_rst) in_rst |=> flash_read_array;
   endproperty
   a_flash: assert property (p_flash) else $error("flash not in read array");

   property p_pwr_clear;
      @(posedge mclk) disable iff (sys_rst) pu_rst && in_rst |=> ctrl0_r == PWR_RESET_VAL && ctrl2_r == PWR_RESET_VAL;
   endproperty
   a_pwr_clear: assert property (p_pwr_clear) else $error("power regs not cleared");

   property p_oth_clear;
      @(posedge mclk) disable iff (sys_rst) in_rst |=> gen_r == GEN_RESET_VAL && map_r == MAP_CFG_VAL;
   endproperty
   a_oth_clear: assert property (p_oth_clear) else $error("map or general reg not reloaded");

   property p_mcf_pu;
      @(posedge mclk) disable iff (sys_rst) pu_rst && in_rst |=> mcf_q == 8'h00;
   endproperty
   a_mcf_pu: assert property (p_mcf_pu) else $error("macrocells not cleared");

   property p_oe_rst;
      @(posedge mclk) disable iff (sys_rst) in_rst |=> !pin_oe_mcu;
   endproperty
   a_oe_rst: assert property (p_oe_rst) else $error("processor pin driven in reset");

   property p_hiz_periph;
      @(posedge mclk) disable iff (sys_rst) in_rst || pd_s |=> pin_hiz_periph;
   endproperty
   a_hiz_periph: assert property (p_hiz_periph) else $error("peripheral pin driven");

   property p_wake;
      @(posedge mclk) disable iff (sys_rst) edge_any && ctrl0_r[C0_TURBO_OFF] |=> pld_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("strobe edge did not wake logic");

   c_wake: cover property (@(posedge mclk) pld_wake);
   c_warm: cover property (@(posedge mclk) rs_r == RS_WARM);
   c_toggle: cover property (@(posedge mclk) pld_gate_toggle);
   c_pu_rst: cover property (@(posedge mclk) pu_rst && in_rst);

endmodule // pld_input_blocking_reset_state
`default_nettype wire

// [test/proc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module proc_model
   import pld_gate_pkg::*;
(
   // Clock and commands from the bench
   input  wire logic                   mclk,
   input  wire logic                   rst_cmd,
   input  wire logic [3:0]             stb_cmd,
   input  wire logic                   pc7_cmd,
   // Pins toward the block
   output var  logic                   module_reset_n,
   output var  pld_gate_pkg::strobes_t strobes_in,
   output var  logic                   port_c_bit7
);
   always @(posedge mclk) begin
      module_reset_n <= ~rst_cmd;
   end
   // Strobes and port pin change just after the edge
   always @(posedge mclk) begin
      strobes_in  <= stb_cmd;
      port_c_bit7 <= pc7_cmd;
   end
endmodule // proc_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pld_gate_pkg::*;
   // ------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------
   logic       mclk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0, stb = 4'h0;
   logic [7:0] avs_writedata = 8'h00, avs_readdata, mcf_q, mem_map, q, c2, nw, ng;
   logic       avs_waitrequest, flash_read_array, bus_pc7, bus_clk, mcf_clk, sleep_clk;
   logic       pld_wake, pld_gate_toggle, pld_ready, warm_reset, pin_oe_mcu, pin_hiz_latch;
   logic       pin_hiz_periph, jtag_active, cfg_write_ok, module_reset_n, port_c_bit7;
   logic       rst = 1'b0, pc7 = 1'b0, pd1 = 1'b0, pd = 1'b0, jp = 1'b0, fp = 1'b0, ce = 1'b1;
   logic [1:0] avs_response, r;
   strobes_t   strobes_in, mem_strobes, bus_strobes;
   int         mismatches = 0, n_checks = 0, seed;
   int         shadow [0:5] = '{default: 0};

   always #20 mclk = ~mclk;

   proc_model u_core (.mclk, .rst_cmd(rst), .stb_cmd(stb), .pc7_cmd(pc7), .module_reset_n, .strobes_in,
                      .port_c_bit7);
   pld_input_blocking_reset_state u_dut (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .avs_response, .module_reset_n, .strobes_in, .port_c_bit7,
      .port_d_bit1(pd1), .clk_pin_enabled(ce), .power_down(pd), .jtag_active_in(1'b1), .jtag_prog_cfg(jp),
      .fw_prog_cfg(fp), .mem_strobes, .flash_read_array, .bus_strobes, .bus_pc7, .bus_clk, .mcf_clk, .sleep_clk,
      .pld_wake, .pld_gate_toggle, .pld_ready, .warm_reset, .mcf_q, .mem_map, .pin_oe_mcu, .pin_hiz_latch,
      .pin_hiz_periph, .jtag_active, .cfg_write_ok);

   // ------------------------------------------------------------
   // Compare, bus and closing tasks
   // ------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic av(input logic w, input logic [3:0] a, input logic [7:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= ~w;
      do begin
         @(posedge mclk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      r = avs_response;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   // Model drops writes during module reset or power-down
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      av(1'b1, a, d);
      if (!rst && !pd) shadow[a] = d;
   endtask
   task automatic rchk(input logic [3:0] a);
      av(1'b0, a, 8'h00);
      chk8(q, shadow[a][7:0]);
      chk8({6'h0, r}, {6'h0, RESP_OKAY});
   endtask
   // One module reset, power-up or warm
   task automatic rst_phase(input logic warm);
      rst <= 1'b1;
      cyc(6);
      if (!warm) shadow[0] = PWR_RESET_VAL;
      if (!warm) shadow[1] = PWR_RESET_VAL;
      shadow[4] = GEN_RESET_VAL;
      wr(ADDR_CTRL2, 8'h55);
      rchk(ADDR_CTRL0);
      rchk(ADDR_CTRL2);
      rchk(ADDR_GENREG);
      shadow[2] = {6'h0, warm, 1'b1};
      shadow[2][0] = 1'b1;
      shadow[2][1] = 1'b1;
      shadow[2][2] = warm;
      rchk(ADDR_STATUS);
      chk1(flash_read_array, 1'b1);
      chk1(pld_ready, 1'b1);
      chk1(warm_reset, warm);
      chk8(mcf_q, warm ? MCF_PRESET : 8'h00);
      chk8(mem_map, MAP_CFG_VAL);
      chk1(pin_oe_mcu, 1'b0);
      chk1(pin_hiz_latch, 1'b1);
      chk1(pin_hiz_periph, 1'b1);
      chk1(jtag_active, 1'b1);
      rst <= 1'b0;
      cyc(6);
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      seed = $urandom(70);
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      cyc(2);
      rchk(ADDR_CTRL0);
      rchk(ADDR_CTRL2);
      av(1'b0, 4'hF, 8'h00);
      chk8(q, 8'h00);
      chk8({6'h0, r}, {6'h0, RESP_DECERR});
      // Random blocking masks against random strobes
      for (int i = 0; i < 12; i++) begin
         c2 = 8'($urandom);
         wr(ADDR_CTRL2, c2);
         stb <= 4'($urandom);
         pc7 <= 1'($urandom);
         cyc(6);
         chk8({4'h0, bus_strobes}, {4'h0, stb & ~{c2[C2_BLK_RD], c2[C2_BLK_WR], c2[C2_BLK_FETCH], c2[C2_BLK_ALE]}});
         chk8({4'h0, mem_strobes}, {4'h0, stb});
         chk1(bus_pc7, pc7 & ~c2[C2_BLK_PC7]);
         rchk(ADDR_CTRL2);
      end
      // Shared clock gating, every mask with pin and pin enable high and low
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_CTRL0, {2'h0, i[1:0], 4'h0});
         pd1 <= i[2];
         ce  <= ~i[3];
         cyc(6);
         chk1(bus_clk, i[2] & ~i[3] & ~i[0]);
         chk1(mcf_clk, i[2] & ~i[3] & ~i[1]);
         chk1(sleep_clk, i[2] & ~i[3]);
      end
      // Strobe edge with turbo on and off, blocked and not
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CTRL0, {4'h0, i[0], 3'h0});
         wr(ADDR_CTRL2, {5'h0, i[1], 2'h0});
         cyc(4);
         nw = 8'h00;
         ng = 8'h00;
         stb <= stb ^ 4'h8;
         repeat (8) begin
            @(posedge mclk);
            nw += {7'h0, pld_wake};
            ng += {7'h0, pld_gate_toggle};
         end
         chk8(nw, {7'h0, i[0] & ~i[1]});
         chk8(ng, {7'h0, ~i[0] & ~i[1]});
      end
      wr(ADDR_CTRL0, 8'h38);
      wr(ADDR_CTRL2, 8'h7C);
      wr(ADDR_GENREG, 8'hA5);
      wr(ADDR_MAPCFG, 8'hC3);
      rst_phase(1'b0);
      wr(ADDR_CTRL0, 8'h38);
      wr(ADDR_CTRL2, 8'h7C);
      wr(ADDR_GENREG, 8'hA5);
      wr(ADDR_MAPCFG, 8'hC3);
      rst_phase(1'b1);
      // Power-down keeps registers and processor pin state, floats peripheral pins
      wr(ADDR_GENREG, 8'h5A);
      pd <= 1'b1;
      cyc(6);
      wr(ADDR_CTRL0, 8'h00);
      rchk(ADDR_CTRL0);
      rchk(ADDR_GENREG);
      chk8(mem_map, MAP_CFG_VAL);
      chk1(pin_hiz_periph, 1'b1);
      chk1(jtag_active, 1'b1);
      chk1(pin_oe_mcu, 1'b1);
      pd <= 1'b0;
      // Configuration writes only from the serial test port
      for (int i = 0; i < 4; i++) begin
         jp <= i[0];
         fp <= i[1];
         cyc(4);
         chk1(cfg_write_ok, i[0]);
      end
      tally_and_finish();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
